// >>> dsc_device_state_control.sv
// operating-state sequencer and status/control word of the synthesizer
`timescale 1ns/1ps
module dsc_device_state_control
  import dsc_pkg::*;
#(
  parameter int POR_CYCLES = POR_DELAY_CYCLES,
  parameter int LOAD_CYCLES = NV_LOAD_CYCLES,
  parameter logic [2:0] VERSION = VERSION_VALUE // arbitrary value
)
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_reset_n, // power applied, active low
  input wire logic i_power_down_n, // power-down pin, low shuts down
  input wire logic i_sync_n, // sync pin, active low
  input wire logic i_serial_clk, // serial clock
  input wire logic i_serial_data, // serial data in
  input wire logic i_serial_latch_enable, // serial latch enable
  input wire logic i_cal_done, // oscillator calibration finished
  input wire logic [5:0] i_osc_tune_result, // calibration word from core
  input wire logic i_pll_locked, // lock detector
  input wire logic i_primary_source_active, // primary reference feeds pll
  input wire logic i_secondary_source_active, // secondary reference feeds pll
  input wire logic i_auxiliary_source_active, // auxiliary input feeds pll
  output logic o_serial_out, // serial data out
  output logic o_serial_port_on, // serial port enabled
  output logic o_pll_enable, // pll enabled
  output logic o_divider_enable, // output dividers running
  output logic o_divider_hold, // dividers held for alignment
  output logic o_output_enable, // output buffers driving
  output logic o_output_hiz, // output buffers high-impedance
  output logic o_cal_run, // oscillator calibration in progress
  output logic o_lock_output_level, // lock pin level
  output logic [2:0] o_state // current state code
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  dsc_state_type state_q;
  dsc_state_type state_d;
  logic pd_prev_q;
  logic timers_start;
  logic por_done;
  logic load_done;
  logic load_req_q;
  logic sleep_q;
  logic sync_q;
  logic [5:0] tune_override_q;
  logic [3:0] test_config_q;
  logic manual_tune_select_q;
  logic tune_trigger_q;
  logic trigger_prev_q;
  logic trigger_rise;
  logic [5:0] tune_result_q;
  logic [2:0] source_q;
  logic div_access_q;
  logic wr;
  logic [ADDR_BITS-1:0] addr;
  logic [DATA_BITS-1:0] wdata;
  logic [DATA_BITS-1:0] status_word;
  logic [DATA_BITS-1:0] cal_config_word;
  logic [DATA_BITS-1:0] read_data;
  logic sync_req;
  logic port_on;
  logic recal_req;

  // ------------------------------------------------------------
  // serial port and delay timers
  // ------------------------------------------------------------
  dsc_serial u_serial (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_port_on(port_on),
    .i_serial_clk(i_serial_clk),
    .i_serial_data(i_serial_data),
    .i_serial_latch_enable(i_serial_latch_enable),
    .i_read_data(read_data),
    .o_write(wr),
    .o_addr(addr),
    .o_wdata(wdata),
    .o_serial_out(o_serial_out)
  );

  // timers restart on power-up and on power-down pin release
  assign timers_start = (state_q == ST_POR) && load_req_q;

  dsc_timer u_por_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_start(timers_start),
    .i_cycles(TIMER_WIDTH'(POR_CYCLES)),
    .o_done(por_done)
  );

  dsc_timer u_load_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_start(timers_start),
    .i_cycles(TIMER_WIDTH'(LOAD_CYCLES)),
    .o_done(load_done)
  );

  // ------------------------------------------------------------
  // control decode
  // ------------------------------------------------------------
  // serial port is live outside power-on reset and power-down
  assign port_on = (state_q != ST_POR) && (state_q != ST_POWER_DOWN);

  // sync pin and sync bit both force the sync state
  assign sync_req = !sync_q || !i_sync_n || div_access_q;

  // trigger rise detected on the stored trigger bit
  assign trigger_rise = tune_trigger_q && !trigger_prev_q;
  assign recal_req = manual_tune_select_q && trigger_rise;

  // ------------------------------------------------------------
  // load request from power-up or power-down pin rise
  // ------------------------------------------------------------
  // a pending request starts both timers and the settings copy
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      load_req_q <= 1'b1;
      pd_prev_q <= 1'b1; // idle level, no false rise after reset
    end
    else
    begin
      pd_prev_q <= i_power_down_n;
      if (i_power_down_n && !pd_prev_q)
        load_req_q <= 1'b1;
      else if (state_q == ST_POR)
        load_req_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  // next state, power-down first, then sleep, sync, recalibration
  always_comb
  begin
    state_d = state_q;
    if (!i_power_down_n)
    begin
      state_d = ST_POWER_DOWN;
    end
    else
    begin
      unique case (state_q)
        ST_POWER_DOWN:
          if (load_req_q || pd_prev_q == 1'b0)
            state_d = ST_POR;
        ST_POR:
          if (!load_req_q && por_done && load_done)
            state_d = ST_CAL_HOLD;
        ST_CAL_HOLD:
          if (!sleep_q)
            state_d = ST_SLEEP;
          else if (!manual_tune_select_q || trigger_rise)
            state_d = ST_VCO_CAL;
        ST_VCO_CAL:
          if (!sleep_q)
            state_d = ST_SLEEP;
          else if (i_cal_done)
            state_d = ST_ACTIVE;
        ST_ACTIVE:
          if (!sleep_q)
            state_d = ST_SLEEP;
          else if (sync_req)
            state_d = ST_SYNC;
          else if (recal_req)
            state_d = ST_VCO_CAL;
        ST_SLEEP:
          if (sleep_q)
            state_d = ST_CAL_HOLD;
        ST_SYNC:
          if (!sleep_q)
            state_d = ST_SLEEP;
          else if (!sync_req)
            state_d = ST_ACTIVE;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      state_q <= ST_POR;
    else
      state_q <= state_d;
  end

  // ------------------------------------------------------------
  // working registers
  // ------------------------------------------------------------
  // sleep and sync bits, reloaded from non-volatile defaults
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      sleep_q <= NV_SLEEP_RESET;
      sync_q <= NV_SYNC_RESET;
      tune_override_q <= '0;
      test_config_q <= '0;
    end
    else if (timers_start)
    begin
      sleep_q <= NV_SLEEP_RESET;
      sync_q <= NV_SYNC_RESET;
      tune_override_q <= '0;
      test_config_q <= '0;
    end
    else if (wr && addr == STATUS_CONTROL_ADDR)
    begin
      sleep_q <= wdata[SLEEP_BIT];
      sync_q <= wdata[SYNC_BIT];
      tune_override_q <= wdata[TUNE_OVERRIDE_MSB:TUNE_OVERRIDE_LSB];
      test_config_q <= wdata[TEST_CONFIG_MSB:TEST_CONFIG_LSB];
    end
  end

  // calibration mode and trigger bits with edge history
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      manual_tune_select_q <= NV_MANUAL_TUNE_RESET;
      tune_trigger_q <= NV_TUNE_TRIGGER_RESET;
      trigger_prev_q <= NV_TUNE_TRIGGER_RESET;
    end
    else
    begin
      trigger_prev_q <= tune_trigger_q;
      if (timers_start)
      begin
        manual_tune_select_q <= NV_MANUAL_TUNE_RESET;
        tune_trigger_q <= NV_TUNE_TRIGGER_RESET;
        trigger_prev_q <= NV_TUNE_TRIGGER_RESET;
      end
      else if (wr && addr == CAL_CONFIG_ADDR)
      begin
        manual_tune_select_q <= wdata[MANUAL_TUNE_SELECT_BIT];
        tune_trigger_q <= wdata[TUNE_TRIGGER_BIT];
      end
    end
  end

  // divider register write forces one cycle of sync
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      div_access_q <= 1'b0;
    else
      div_access_q <= wr && (addr <= LAST_DIVIDER_ADDR);
  end

  // calibration word captured at the end of calibration
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      tune_result_q <= '0;
    else if (state_q == ST_VCO_CAL && i_cal_done)
      tune_result_q <= i_osc_tune_result;
  end

  // source indicator and lock level sampling
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      source_q <= '0;
      o_lock_output_level <= 1'b0;
    end
    else
    begin
      source_q <= {i_auxiliary_source_active, i_secondary_source_active,
                   i_primary_source_active};
      o_lock_output_level <= i_pll_locked && o_pll_enable;
    end
  end

  // ------------------------------------------------------------
  // read-back words
  // ------------------------------------------------------------
  // status/control word, reserved bits read zero
  always_comb
  begin
    status_word = '0;
    status_word[TUNE_RESULT_MSB:TUNE_RESULT_LSB] = tune_result_q;
    status_word[LOCK_LEVEL_BIT] = o_lock_output_level;
    status_word[SLEEP_BIT] = sleep_q;
    status_word[SYNC_BIT] = sync_q;
    status_word[VERSION_MSB:VERSION_LSB] = VERSION;
    status_word[TUNE_OVERRIDE_MSB:TUNE_OVERRIDE_LSB] = tune_override_q;
    status_word[TEST_CONFIG_MSB:TEST_CONFIG_LSB] = test_config_q;
    status_word[SOURCE_MSB:SOURCE_LSB] = source_q;
  end

  // calibration configuration word holds only the two mode bits
  always_comb
  begin
    cal_config_word = '0;
    cal_config_word[MANUAL_TUNE_SELECT_BIT] = manual_tune_select_q;
    cal_config_word[TUNE_TRIGGER_BIT] = tune_trigger_q;
  end

  // read select, other registers read zero
  always_comb
  begin
    if (addr == STATUS_CONTROL_ADDR)
      read_data = status_word;
    else if (addr == CAL_CONFIG_ADDR)
      read_data = cal_config_word;
    else
      read_data = '0;
  end

  // ------------------------------------------------------------
  // per-state controls
  // ------------------------------------------------------------
  // registered block enables from the next state
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      o_serial_port_on <= 1'b0;
      o_pll_enable <= 1'b0;
      o_divider_enable <= 1'b0;
      o_divider_hold <= 1'b0;
      o_output_enable <= 1'b0;
      o_output_hiz <= 1'b0;
      o_cal_run <= 1'b0;
      o_state <= 3'(ST_POR);
    end
    else
    begin
      o_state <= 3'(state_d);
      o_serial_port_on <= (state_d != ST_POR) && (state_d != ST_POWER_DOWN);
      o_pll_enable <= (state_d == ST_CAL_HOLD) || (state_d == ST_VCO_CAL) ||
                      (state_d == ST_ACTIVE) || (state_d == ST_SYNC);
      o_divider_enable <= (state_d == ST_ACTIVE);
      o_divider_hold <= (state_d == ST_SYNC);
      o_output_enable <= (state_d == ST_ACTIVE);
      o_output_hiz <= (state_d == ST_POWER_DOWN) || (state_d == ST_SLEEP) ||
                      (state_d == ST_SYNC);
      o_cal_run <= (state_d == ST_VCO_CAL);
    end
  end

endmodule // dsc_device_state_control

// >>> dsc_device_state_control_sva.sv
// assertion checker for the device state control block
`timescale 1ns/1ps
module dsc_device_state_control_sva
  import dsc_pkg::*;
(
  input wire logic i_ref_clk, // clock
  input wire logic i_reset_n, // reset, active low
  input wire logic i_power_down_n, // power-down pin
  input wire logic i_sync_n, // sync pin
  input wire logic i_cal_done, // calibration finished
  input wire logic i_pll_locked, // lock detector
  input wire logic o_serial_port_on, // port on
  input wire logic o_pll_enable, // pll on
  input wire logic o_divider_enable, // dividers on
  input wire logic o_divider_hold, // dividers held
  input wire logic o_output_enable, // outputs on
  input wire logic o_output_hiz, // outputs floating
  input wire logic o_cal_run, // calibration running
  input wire logic o_lock_output_level, // lock pin
  input wire logic [2:0] o_state // state code
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ------------------------------------------------------------
  // state moves and output levels
  // ------------------------------------------------------------
  a_pd_first: assert property (!i_power_down_n |=> o_state == ST_POWER_DOWN)
    else $error("power-down not taken");
  a_por_quiet: assert property (o_state == ST_POR |-> !(o_serial_port_on || o_pll_enable
    || o_divider_enable || o_output_enable)) else $error("reset state not quiet");
  a_hold_levels: assert property (o_state == ST_CAL_HOLD |-> o_serial_port_on && o_pll_enable
    && !o_divider_enable && !o_output_enable) else $error("hold levels wrong");
  a_cal_levels: assert property (o_state == ST_VCO_CAL |-> o_cal_run && o_pll_enable
    && o_serial_port_on && !o_divider_enable && !o_output_enable) else $error("cal levels wrong");
  a_cal_active: assert property (o_state == ST_VCO_CAL && i_cal_done && i_power_down_n
    |=> o_state inside {ST_ACTIVE, ST_SLEEP}) else $error("calibration did not end");
  a_active_levels: assert property (o_state == ST_ACTIVE |-> o_serial_port_on && o_pll_enable
    && o_divider_enable && o_output_enable) else $error("active levels wrong");
  a_sleep_levels: assert property (o_state == ST_SLEEP |-> o_serial_port_on && !o_pll_enable
    && !o_divider_enable && o_output_hiz) else $error("sleep levels wrong");
  a_sync_pin: assert property (o_state == ST_ACTIVE && !i_sync_n && i_power_down_n
    |=> o_state inside {ST_SYNC, ST_SLEEP}) else $error("sync pin ignored");
  a_sync_levels: assert property (o_state == ST_SYNC |-> o_divider_hold && !o_divider_enable
    && o_output_hiz) else $error("sync levels wrong");
  a_lock_cause: assert property (o_lock_output_level |-> $past(i_pll_locked))
    else $error("lock pin without lock");
  // main scenarios reached
  c_active: cover property (o_state == ST_ACTIVE);
  c_sleep: cover property (o_state == ST_SLEEP);
  c_sync: cover property (o_state == ST_SYNC);
endmodule // dsc_device_state_control_sva

bind dsc_device_state_control dsc_device_state_control_sva u_sva (.i_ref_clk, .i_reset_n,
  .i_power_down_n, .i_sync_n, .i_cal_done, .i_pll_locked, .o_serial_port_on, .o_pll_enable,
  .o_divider_enable, .o_divider_hold, .o_output_enable, .o_output_hiz, .o_cal_run,
  .o_lock_output_level, .o_state);

// >>> dsc_device_state_control_tb_top.sv
// self-checking testbench for the device state control block
`timescale 1ns/1ps
module dsc_device_state_control_tb_top import dsc_pkg::*;;
  logic i_ref_clk, i_reset_n, i_power_down_n, i_sync_n, i_serial_clk, i_serial_data;
  logic i_serial_latch_enable, o_serial_out, o_serial_port_on, o_pll_enable, o_divider_enable;
  logic o_divider_hold, o_output_enable, o_output_hiz, o_cal_run, o_lock_output_level;
  logic i_cal_done = 1'h0;
  logic i_pll_locked = 1'h1;
  logic i_primary_source_active = 1'h0;
  logic i_secondary_source_active = 1'h1;
  logic i_auxiliary_source_active = 1'h0;
  logic [5:0] i_osc_tune_result = 6'h2A;
  logic [2:0] o_state;
  logic [31:0] rx;
  int n_errors = 0, num_checks = 0, n_cal = 0, n_sync = 0;
  // clock and parts
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  dsc_device_state_control dut (.i_ref_clk, .i_reset_n, .i_power_down_n, .i_sync_n,
    .i_serial_clk, .i_serial_data, .i_serial_latch_enable, .i_cal_done, .i_osc_tune_result,
    .i_pll_locked, .i_primary_source_active, .i_secondary_source_active,
    .i_auxiliary_source_active, .o_serial_out, .o_serial_port_on, .o_pll_enable,
    .o_divider_enable, .o_divider_hold, .o_output_enable, .o_output_hiz, .o_cal_run,
    .o_lock_output_level, .o_state);
  dsc_host_model host (.i_ref_clk, .i_serial_out(o_serial_out), .o_power_down_n(i_power_down_n),
    .o_sync_n(i_sync_n), .o_serial_clk(i_serial_clk), .o_serial_data(i_serial_data),
    .o_serial_latch_enable(i_serial_latch_enable));
  // calibration core stand-in, finishes one cycle after start
  always @(posedge i_ref_clk)
  begin
    i_cal_done <= o_cal_run && !i_cal_done;
    if (i_cal_done)
      n_cal <= n_cal + 1;
    if (o_divider_hold)
      n_sync <= n_sync + 1;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task wait_st(input logic [2:0] s);
    for (int i = 0; i < 200 && o_state !== s; i++)
      tick(1);
  endtask
  task wr(input logic [3:0] a, input logic [27:0] d);
    host.send(a, d, rx);
    #1;
  endtask
  task rd8(output logic [27:0] v);
    wr(4'hE, 28'h8);
    wr(4'hF, 28'h0);
    v = rx[31:4];
  endtask
  task t_power_up;
    int n;
    logic [27:0] v;
    n = 0;
    chk("por state", o_state, ST_POR);
    chk("por levels", {o_serial_port_on, o_pll_enable, o_output_enable}, 3'h0);
    for (; n < 100 && o_state === ST_POR; n++)
      tick(1);
    chk("por length", n >= POR_DELAY_CYCLES && n <= POR_DELAY_CYCLES + 4, 1'h1);
    chk("hold", o_state, ST_CAL_HOLD);
    tick(1);
    chk("auto cal", o_state, ST_VCO_CAL);
    wait_st(ST_ACTIVE);
    chk("active", o_state, ST_ACTIVE);
    wr(STATUS_CONTROL_ADDR, 28'h1FF);
    rd8(v);
    chk("status", v, {3'h2, 12'h0, VERSION_VALUE, 1'h0, 2'h3, 1'h1, 6'h2A});
    $display("test power_up done");
  endtask
  task t_recal;
    int c;
    logic [27:0] v;
    c = n_cal;
    @(posedge i_ref_clk) i_osc_tune_result <= 6'h15;
    i_pll_locked <= 1'b0;
    wr(CAL_CONFIG_ADDR, 28'h8000000);
    wr(CAL_CONFIG_ADDR, 28'h8400000);
    wait_st(ST_ACTIVE);
    chk("recal count", n_cal - c, 1);
    rd8(v);
    chk("new word", v[6:0], 7'h15);
    $display("test recal done");
  endtask
  task t_sleep;
    wr(STATUS_CONTROL_ADDR, 28'h100);
    chk("sleep", o_state, ST_SLEEP);
    chk("sleep levels", {o_serial_port_on, o_pll_enable, o_divider_enable, o_output_hiz}, 4'h9);
    wr(STATUS_CONTROL_ADDR, 28'h180);
    chk("wake hold", o_state, ST_CAL_HOLD);
    chk("hold levels", {o_serial_port_on, o_pll_enable, o_divider_enable}, 3'h6);
    wr(CAL_CONFIG_ADDR, 28'h8000000);
    wr(CAL_CONFIG_ADDR, 28'h8400000);
    wait_st(ST_ACTIVE);
    chk("manual cal", o_state, ST_ACTIVE);
    $display("test sleep done");
  endtask
  task t_sync;
    int c;
    chk("active levels", {o_divider_enable, o_output_enable}, 2'h3);
    wr(STATUS_CONTROL_ADDR, 28'h080);
    chk("sync bit", o_state, ST_SYNC);
    chk("sync levels", {o_divider_hold, o_divider_enable, o_output_hiz}, 3'h5);
    wr(STATUS_CONTROL_ADDR, 28'h180);
    chk("sync off", o_state, ST_ACTIVE);
    c = n_sync;
    wr(4'h0, 28'h0);
    chk("div sync", n_sync - c, 1);
    chk("div back", o_state, ST_ACTIVE);
    host.pins(1'b1, 1'b0);
    tick(2);
    chk("sync pin", o_state, ST_SYNC);
    host.pins(1'b1, 1'b1);
    tick(2);
    chk("pin off", o_state, ST_ACTIVE);
    $display("test sync done");
  endtask
  task t_power_down;
    int c;
    host.pins(1'b0, 1'b0);
    tick(2);
    chk("pd first", o_state, ST_POWER_DOWN);
    chk("pd levels", {o_serial_port_on, o_pll_enable, o_output_hiz}, 3'h1);
    c = n_cal;
    host.pins(1'b1, 1'b1);
    tick(2);
    chk("pd exit", o_state, ST_POR);
    wait_st(ST_ACTIVE);
    chk("reloaded auto", n_cal - c, 1);
    $display("test power_down done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    i_reset_n = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    tick(1);
    t_power_up;
    t_recal;
    t_sleep;
    t_sync;
    t_power_down;
    finish_test;
  end
  // watchdog against a hang
  initial
  begin
    #100000;
    n_errors++;
    finish_test;
  end
endmodule // dsc_device_state_control_tb_top

// >>> dsc_host_model.sv
// host controller model: control pins and serial frames
`timescale 1ns/1ps
module dsc_host_model
  import dsc_pkg::*;
(
  input wire logic i_ref_clk, // clock
  input wire logic i_serial_out, // read-back data
  output logic o_power_down_n, // power-down pin
  output logic o_sync_n, // sync pin
  output logic o_serial_clk, // serial clock, still between frames
  output logic o_serial_data, // serial data
  output logic o_serial_latch_enable // latch enable, high when idle
);
  // idle levels; latch high so a power-down rise reloads cleanly
  initial
  begin
    o_power_down_n = 1'b1;
    o_sync_n = 1'b1;
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_serial_latch_enable = 1'b1;
  end
  // pin levels change on a clock edge
  task automatic pins(input logic pd_n, input logic sy_n);
    @(posedge i_ref_clk) o_power_down_n <= pd_n;
    o_sync_n <= sy_n;
  endtask
  // one frame lsb first, read-back sampled before each rise
  task automatic send(input logic [3:0] a, input logic [27:0] d, output logic [31:0] rx);
    logic [31:0] f;
    f = {(a == STATUS_CONTROL_ADDR) ? (d & 28'hE001DFF) : d, a};
    @(posedge i_ref_clk) o_serial_latch_enable <= 1'b0;
    for (int k = 0; k < FRAME_BITS; k++)
    begin
      @(posedge i_ref_clk) o_serial_clk <= 1'b0;
      o_serial_data <= f[k];
      @(posedge i_ref_clk);
      @(posedge i_ref_clk) rx[k] = i_serial_out;
      o_serial_clk <= 1'b1;
    end
    @(posedge i_ref_clk) o_serial_clk <= 1'b0;
    o_serial_data <= ~f[31];
    @(posedge i_ref_clk) o_serial_latch_enable <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
  endtask
endmodule // dsc_host_model

// >>> dsc_pkg.sv
// constants, register map and state type of the device state control block
package dsc_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NV_LOAD_TIME_NS = 100;
  localparam int NV_LOAD_CYCLES = NV_LOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int POR_DELAY_CYCLES = 16;
  localparam int TIMER_WIDTH = 8;

  // ------------------------------------------------------------
  // serial frame
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 28;
  localparam logic [3:0] READ_CMD_ADDR = 4'hE;
  localparam logic [3:0] LAST_DIVIDER_ADDR = 4'h4;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] CAL_CONFIG_ADDR = 4'h6;
  localparam logic [3:0] STATUS_CONTROL_ADDR = 4'h8;

  // ------------------------------------------------------------
  // calibration configuration fields
  // ------------------------------------------------------------
  localparam int MANUAL_TUNE_SELECT_BIT = 27;
  localparam int TUNE_TRIGGER_BIT = 22;

  // ------------------------------------------------------------
  // status/control fields
  // ------------------------------------------------------------
  localparam int TUNE_RESULT_LSB = 0;
  localparam int TUNE_RESULT_MSB = 5;
  localparam int LOCK_LEVEL_BIT = 6;
  localparam int SLEEP_BIT = 7;
  localparam int SYNC_BIT = 8;
  localparam int VERSION_LSB = 10;
  localparam int VERSION_MSB = 12;
  localparam int TUNE_OVERRIDE_LSB = 14;
  localparam int TUNE_OVERRIDE_MSB = 19;
  localparam int TEST_CONFIG_LSB = 21;
  localparam int TEST_CONFIG_MSB = 24;
  localparam int SOURCE_LSB = 25;
  localparam int SOURCE_MSB = 27;

  // ------------------------------------------------------------
  // non-volatile defaults
  // ------------------------------------------------------------
  localparam logic NV_SLEEP_RESET = 1'b1;
  localparam logic NV_SYNC_RESET = 1'b1;
  localparam logic NV_MANUAL_TUNE_RESET = 1'b0;
  localparam logic NV_TUNE_TRIGGER_RESET = 1'b0;
  localparam logic [2:0] VERSION_VALUE = 3'h1;

  // ------------------------------------------------------------
  // operating states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_POR,
    ST_CAL_HOLD,
    ST_VCO_CAL,
    ST_ACTIVE,
    ST_SLEEP,
    ST_SYNC
  } dsc_state_type;

endpackage

// >>> dsc_serial.sv
// serial port slave: shifts 32-bit frames, issues writes and read selects
`timescale 1ns/1ps
module dsc_serial
  import dsc_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_port_on, // serial port powered
  input wire logic i_serial_clk, // serial clock, sampled
  input wire logic i_serial_data, // serial data in
  input wire logic i_serial_latch_enable, // frame latch, low during frame
  input wire logic [DATA_BITS-1:0] i_read_data, // selected register contents
  output logic o_write, // write pulse
  output logic [ADDR_BITS-1:0] o_addr, // write or read address
  output logic [DATA_BITS-1:0] o_wdata, // write data
  output logic o_serial_out // serial data out
);

  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] out_q;
  logic [5:0] bits_q;
  logic clk_prev_q;
  logic le_prev_q;
  logic [ADDR_BITS-1:0] rd_sel_q;
  logic clk_rise;
  logic le_rise;
  logic le_fall;

  assign clk_rise = i_serial_clk && !clk_prev_q;
  assign le_rise = i_serial_latch_enable && !le_prev_q;
  assign le_fall = !i_serial_latch_enable && le_prev_q;

  // edge history of the serial pins
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      clk_prev_q <= 1'b0;
      le_prev_q <= 1'b1;
    end
    else
    begin
      clk_prev_q <= i_serial_clk;
      le_prev_q <= i_serial_latch_enable;
    end
  end

  // frame shifter, lsb first, counts bits up to a full frame
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !i_port_on)
    begin
      shift_q <= '0;
      bits_q <= '0;
    end
    else if (le_fall)
    begin
      bits_q <= '0;
    end
    else if (clk_rise && !i_serial_latch_enable)
    begin
      shift_q <= {i_serial_data, shift_q[FRAME_BITS-1:1]};
      if (bits_q != 6'(FRAME_BITS))
        bits_q <= bits_q + 6'h01;
    end
  end

  // latch enable rise completes a frame; read command only selects
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !i_port_on)
    begin
      o_write <= 1'b0;
      o_addr <= '0;
      o_wdata <= '0;
      rd_sel_q <= STATUS_CONTROL_ADDR;
    end
    else
    begin
      o_write <= 1'b0;
      if (le_rise && bits_q == 6'(FRAME_BITS))
      begin
        if (shift_q[ADDR_BITS-1:0] == READ_CMD_ADDR)
        begin
          rd_sel_q <= shift_q[ADDR_BITS+3:ADDR_BITS];
          o_addr <= shift_q[ADDR_BITS+3:ADDR_BITS];
        end
        else
        begin
          o_write <= 1'b1;
          o_addr <= shift_q[ADDR_BITS-1:0];
          o_wdata <= shift_q[FRAME_BITS-1:ADDR_BITS];
        end
      end
      else
      begin
        o_addr <= rd_sel_q; // park on read select so frame start loads it
      end
    end
  end

  // read-back shifter, loaded at frame start, lsb first
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !i_port_on)
    begin
      out_q <= '0;
      o_serial_out <= 1'b0;
    end
    else if (le_fall)
    begin
      out_q <= {i_read_data, rd_sel_q};
      o_serial_out <= rd_sel_q[0];
    end
    else if (clk_rise && !i_serial_latch_enable)
    begin
      out_q <= {1'b0, out_q[FRAME_BITS-1:1]};
      o_serial_out <= out_q[1];
    end
  end

endmodule // dsc_serial

// >>> dsc_timer.sv
// one-shot delay counter, done level after a programmed number of cycles
`timescale 1ns/1ps
module dsc_timer
  import dsc_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
)
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_start, // restart pulse
  input wire logic [WIDTH-1:0] i_cycles, // delay length
  output logic o_done // delay elapsed
);

  logic [WIDTH-1:0] count_q;

  // count down from start, hold done until next start
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      count_q <= '0;
      o_done <= 1'b0;
    end
    else if (i_start)
    begin
      count_q <= i_cycles;
      o_done <= 1'b0;
    end
    else if (count_q > WIDTH'(1))
    begin
      count_q <= count_q - WIDTH'(1);
    end
    else if (!o_done)
    begin
      count_q <= '0;
      o_done <= 1'b1;
    end
  end

endmodule // dsc_timer
